// ### verilog/plrs_top.sv
/*
 * Phy side of the phy-link interface: bus request handling, register
 * read and write requests, and status transfers on the control and data
 * lines, with an APB slave for control and visibility.
 * Assumes the link shares pclk, the arbiter reports won and the serial
 * receiver reports packet activity synchronously to pclk.
 */
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`include "plrs_consts.svh"

module plrs_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Phy-link pins
	input  wire logic        link_request_line,
	input  wire logic [1:0]  interface_control_lines_i,
	output logic [1:0]       interface_control_lines_o,
	output logic             interface_control_lines_oe,
	output logic             data_lane_zero_o,
	output logic             data_lane_one_o,
	output logic             data_lanes_oe,
	// Serial bus side of the phy
	input  wire logic        rx_active,
	input  wire logic [1:0]  rx_data,
	input  wire logic        arb_won,
	input  wire logic        evt_arb_reset_gap,
	input  wire logic        evt_subaction_gap,
	input  wire logic        evt_bus_reset,
	output logic             arb_request,
	output logic [2:0]       arb_type,
	output logic [3:0]       arb_prio,
	output logic             bus_take
);

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	plrs_req_if req ();                  // Parsed requests
	plrs_pkg::plrs_state_t state_q;      // Interface activity
	plrs_pkg::plrs_state_t state_d;
	logic [7:0]  phyreg_q [16];          // Phy registers
	logic [2:0]  flags_q;                // Pending status flags
	logic        rd_pend_q;              // Read answer owed
	logic [3:0]  rd_addr_q;              // Address to answer
	logic        req_pend_q;             // Bus request pending
	logic [2:0]  req_type_q;             // Pending request type
	logic [3:0]  req_prio_q;             // Pending request priority
	logic        rxdur_q;                // Receive seen during request
	logic [15:0] word_q;                 // Status stream snapshot
	logic [2:0]  beat_q;                 // Status beat index
	logic [2:0]  last_q;                 // Last beat of this transfer
	logic        full_q;                 // Full stream in flight
	logic [1:0]  rxd_q;                  // Registered receive data
	logic        lidle_q;                // Link drove one idle
	logic [1:0]  ctrl_q;                 // Control register
	logic        apb_wr;                 // APB write strobe
	logic        cancel;                 // Software cancels request
	logic        stat_want;              // Status waiting to go
	logic        stat_done;              // Status transfer completes
	logic        bus_type;               // Done request is a bus request

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	// Phy register window hit
	function automatic logic phy_hit(input logic [7:0] a);
		phy_hit = (a[7:6] == `PLRS_OFF_PHYREG >> 6) && (a[1:0] == 2'h0);
	endfunction

	// Status stream, bit 0 first; address and data most significant first
	function automatic logic [15:0] stat_word(input logic [2:0] fl,
		input logic [3:0] a, input logic [7:0] d, input logic full);
		stat_word = 16'h0000;
		stat_word[2:0] = fl;
		if (full)
		begin
			for (int i = 0; i < 4; i++)
				stat_word[4 + i] = a[3 - i];
			for (int i = 0; i < 8; i++)
				stat_word[8 + i] = d[7 - i];
		end
	endfunction

	// ------------------------------------------------------------------
	// Request receiver
	// ------------------------------------------------------------------
	plrs_req_rx u_req_rx (
		.pclk              (pclk),
		.presetn           (presetn),
		.link_request_line (link_request_line),
		.req               (req)
	);

	assign bus_type  = (req.rtype == `PLRS_RT_IMM) ||
		(req.rtype == `PLRS_RT_ISO) || (req.rtype == `PLRS_RT_PRI) ||
		(req.rtype == `PLRS_RT_FAIR);
	assign apb_wr    = psel && penable && pwrite;
	assign cancel    = apb_wr && (paddr == `PLRS_OFF_CTRL) &&
		pwdata[`PLRS_CTRL_CANCEL];
	assign stat_want = ctrl_q[`PLRS_CTRL_EN_BIT] &&
		((flags_q != 3'h0) || rd_pend_q);
	assign stat_done = (state_q == plrs_pkg::ST_STATUS) && !rx_active &&
		(beat_q == last_q);

	// ------------------------------------------------------------------
	// Interface state machine
	// ------------------------------------------------------------------
	// Next activity on the lines
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			plrs_pkg::ST_IDLE:
				if (rx_active)
					state_d = plrs_pkg::ST_RECV;
				else if (req_pend_q && req_type_q == `PLRS_RT_IMM)
					state_d = plrs_pkg::ST_GRANT;
				else if (arb_won && req_pend_q)
					state_d = plrs_pkg::ST_GRANT;
				else if (stat_want)
					state_d = plrs_pkg::ST_STATUS;
			plrs_pkg::ST_RECV:
				if (!rx_active)
					state_d = (req_pend_q && req_type_q == `PLRS_RT_IMM) ?
						plrs_pkg::ST_GRANT : plrs_pkg::ST_IDLE;
			plrs_pkg::ST_STATUS:
				if (rx_active)
					state_d = plrs_pkg::ST_RECV;
				else if (beat_q == last_q)
					state_d = plrs_pkg::ST_GAP;
			plrs_pkg::ST_GAP:
				state_d = rx_active ? plrs_pkg::ST_RECV : plrs_pkg::ST_IDLE;
			plrs_pkg::ST_GRANT:
				state_d = plrs_pkg::ST_GIDLE;
			plrs_pkg::ST_GIDLE:
				state_d = plrs_pkg::ST_LINK;
			plrs_pkg::ST_LINK:
				// Second idle from the link: resume driving idle next beat
				if (lidle_q && interface_control_lines_i == `PLRS_CTL_IDLE)
					state_d = plrs_pkg::ST_IDLE;
			default:
				state_d = plrs_pkg::ST_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_q <= plrs_pkg::ST_IDLE;
		else
			state_q <= state_d;
	end

	// Count idles driven by the link while it owns the lines
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			lidle_q <= 1'b0;
		else
			lidle_q <= (state_q == plrs_pkg::ST_LINK) &&
				(interface_control_lines_i == `PLRS_CTL_IDLE);
	end

	// ------------------------------------------------------------------
	// Bus requests
	// ------------------------------------------------------------------
	// Receive seen while a request is still being shifted in
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rxdur_q <= 1'b0;
		else if (req.busy)
			rxdur_q <= rxdur_q || (state_q == plrs_pkg::ST_RECV);
		else
			rxdur_q <= 1'b0;
	end

	// Pending request: accept, lose, win
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			req_pend_q <= 1'b0;
			req_type_q <= `PLRS_RT_IMM;
			req_prio_q <= 4'h0;
		end
		else
		begin
			if (state_d == plrs_pkg::ST_GRANT &&
				state_q != plrs_pkg::ST_GRANT)
				req_pend_q <= 1'b0;
			else if (cancel)
				req_pend_q <= 1'b0;
			else if (state_d == plrs_pkg::ST_RECV &&
				state_q != plrs_pkg::ST_RECV &&
				(req_type_q == `PLRS_RT_PRI || req_type_q == `PLRS_RT_FAIR))
				req_pend_q <= 1'b0;
			else if (req.done && bus_type && !req_pend_q &&
				!((rxdur_q || state_q == plrs_pkg::ST_RECV) &&
				(req.rtype == `PLRS_RT_PRI || req.rtype == `PLRS_RT_FAIR)))
			begin
				req_pend_q <= 1'b1;
				req_type_q <= req.rtype;
				req_prio_q <= req.prio;
			end
		end
	end

	assign arb_request = req_pend_q && (req_type_q != `PLRS_RT_IMM);
	assign arb_type    = req_type_q;
	assign arb_prio    = req_prio_q;
	assign bus_take    = (state_q == plrs_pkg::ST_GRANT) &&
		(req_type_q == `PLRS_RT_IMM);

	// ------------------------------------------------------------------
	// Phy registers and read answers
	// ------------------------------------------------------------------
	// Link write requests win over APB writes
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < 16; i++)
				phyreg_q[i] <= 8'h00;
		end
		else if (req.done && req.rtype == `PLRS_RT_WR)
			phyreg_q[req.addr] <= req.wdata;
		else if (apb_wr && phy_hit(paddr))
			phyreg_q[paddr[5:2]] <= pwdata[7:0];
	end

	// Read owed until a full status transfer completes
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rd_pend_q <= 1'b0;
			rd_addr_q <= 4'h0;
		end
		else if (req.done && req.rtype == `PLRS_RT_RD)
		begin
			rd_pend_q <= 1'b1;
			rd_addr_q <= req.addr;
		end
		else if (stat_done && full_q)
			rd_pend_q <= 1'b0;
	end

	// ------------------------------------------------------------------
	// Status flags and transfer
	// ------------------------------------------------------------------
	// Events set flags; only flags actually sent are cleared
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			flags_q <= 3'h0;
		else
			flags_q <= (stat_done ? (flags_q & ~word_q[2:0]) : flags_q) |
				{evt_bus_reset, evt_subaction_gap, evt_arb_reset_gap};
	end

	// Snapshot at start, step two bits per beat
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			word_q <= 16'h0000;
			beat_q <= 3'h0;
			last_q <= `PLRS_LAST_SHORT;
			full_q <= 1'b0;
		end
		else if (state_d == plrs_pkg::ST_STATUS &&
			state_q != plrs_pkg::ST_STATUS)
		begin
			word_q <= stat_word(flags_q, rd_addr_q, phyreg_q[rd_addr_q],
				rd_pend_q);
			beat_q <= 3'h0;
			full_q <= rd_pend_q;
			last_q <= rd_pend_q ? `PLRS_LAST_FULL : `PLRS_LAST_SHORT;
		end
		else if (state_q == plrs_pkg::ST_STATUS)
			beat_q <= beat_q + 3'h1;
	end

	// Receive data registered toward the link
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rxd_q <= 2'h0;
		else
			rxd_q <= rx_data;
	end

	// ------------------------------------------------------------------
	// Line drivers
	// ------------------------------------------------------------------
	// Control code follows the activity; data from flip-flops
	always_comb
	begin
		interface_control_lines_o = `PLRS_CTL_IDLE;
		data_lane_zero_o          = 1'b0;
		data_lane_one_o           = 1'b0;
		case (state_q)
			plrs_pkg::ST_RECV:
			begin
				interface_control_lines_o = `PLRS_CTL_RECEIVE;
				data_lane_zero_o          = rxd_q[0];
				data_lane_one_o           = rxd_q[1];
			end
			plrs_pkg::ST_STATUS:
			begin
				interface_control_lines_o = `PLRS_CTL_STATUS;
				data_lane_zero_o = word_q[{beat_q, 1'b0}];
				data_lane_one_o  = word_q[{beat_q, 1'b1}];
			end
			plrs_pkg::ST_GRANT:
				interface_control_lines_o = `PLRS_CTL_TRANSMIT;
			default:
				interface_control_lines_o = `PLRS_CTL_IDLE;
		endcase
	end

	assign interface_control_lines_oe = (state_q != plrs_pkg::ST_LINK);
	assign data_lanes_oe              = (state_q != plrs_pkg::ST_LINK);

	// ------------------------------------------------------------------
	// APB slave, zero wait states
	// ------------------------------------------------------------------
	// Control register: status enable; cancel bit acts on write only
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl_q <= `PLRS_CTRL_RESET;
		else if (apb_wr && paddr == `PLRS_OFF_CTRL)
			ctrl_q <= {1'b0, pwdata[`PLRS_CTRL_EN_BIT]};
	end

	// Read mux and error on unmapped address
	always_comb
	begin
		prdata  = 32'h00000000;
		pslverr = 1'b0;
		if (paddr == `PLRS_OFF_CTRL)
			prdata = {30'h0, ctrl_q};
		else if (paddr == `PLRS_OFF_STAT)
			prdata = {12'h000, rd_pend_q, flags_q, req_prio_q, req_type_q,
				req_pend_q, 1'b0, state_q};
		else if (phy_hit(paddr))
			prdata = {24'h000000, phyreg_q[paddr[5:2]]};
		else
			pslverr = psel && penable;
	end

	assign pready = 1'b1;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_STATUS_FROM_IDLE: assert property (
		state_q == plrs_pkg::ST_STATUS && $past(state_q) !=
		plrs_pkg::ST_STATUS |-> $past(state_q) == plrs_pkg::ST_IDLE)
		else $error("status began off idle");
	AST_STATUS_CODE: assert property (
		state_q == plrs_pkg::ST_STATUS |->
		interface_control_lines_o == `PLRS_CTL_STATUS &&
		interface_control_lines_oe)
		else $error("status code not held");
	AST_SUSPEND: assert property (
		state_q == plrs_pkg::ST_STATUS && rx_active |=>
		interface_control_lines_o == `PLRS_CTL_RECEIVE)
		else $error("status not suspended");
	AST_GAP_AFTER_STATUS: assert property (
		stat_done |=> interface_control_lines_o == `PLRS_CTL_IDLE ##1
		state_q != plrs_pkg::ST_STATUS)
		else $error("no idle between status transfers");
	AST_SHORT_STATUS: assert property (
		state_q == plrs_pkg::ST_STATUS && beat_q == 3'h0 && !full_q &&
		!rx_active |=> state_q == plrs_pkg::ST_STATUS ##1
		state_q != plrs_pkg::ST_STATUS)
		else $error("short status not two beats");
	AST_WRITE_LOAD: assert property (
		req.done && req.rtype == `PLRS_RT_WR |=>
		phyreg_q[$past(req.addr)] == $past(req.wdata))
		else $error("register write not loaded");
	AST_IGNORE_NEW: assert property (
		req_pend_q && req.done && bus_type |=>
		$stable(req_type_q) && $stable(req_prio_q))
		else $error("new request replaced pending one");
	AST_ISO_HOLD: assert property (
		req_pend_q && req_type_q == `PLRS_RT_ISO && !cancel &&
		!(state_d == plrs_pkg::ST_GRANT) |=> req_pend_q)
		else $error("isochronous request dropped before win");
	AST_IMM_GRANT: assert property (
		state_q == plrs_pkg::ST_RECV && !rx_active && req_pend_q &&
		req_type_q == `PLRS_RT_IMM |=>
		interface_control_lines_o == `PLRS_CTL_TRANSMIT ##1
		interface_control_lines_o == `PLRS_CTL_IDLE ##1
		!interface_control_lines_oe)
		else $error("immediate grant sequence wrong");
	AST_LOST: assert property (
		state_q != plrs_pkg::ST_RECV && rx_active && req_pend_q &&
		(req_type_q == `PLRS_RT_FAIR || req_type_q == `PLRS_RT_PRI) |=>
		!req_pend_q)
		else $error("lost request still pending");
	AST_READ_RETRY: assert property (
		rd_pend_q && state_q == plrs_pkg::ST_STATUS && rx_active |=>
		rd_pend_q)
		else $error("interrupted read answer forgotten");

	COV_FULL_STATUS: cover property (stat_done && full_q);
	COV_IMM_GRANT: cover property (bus_take);
	COV_SUSPEND: cover property (
		state_q == plrs_pkg::ST_STATUS && rx_active);

endmodule

// ### verilog/plrs_consts.svh
/*
 * Constants of the phy-link request and status block: control line codes,
 * request type codes, request lengths, status beats and register offsets.
 * Assumes inclusion by bare name from every file that needs a number.
 */
`ifndef PLRS_CONSTS_SVH
`define PLRS_CONSTS_SVH

// ------------------------------------------------------------------
// Control line codes
// ------------------------------------------------------------------
`define PLRS_CTL_IDLE     2'h0
`define PLRS_CTL_STATUS   2'h1
`define PLRS_CTL_RECEIVE  2'h2
`define PLRS_CTL_TRANSMIT 2'h3

// ------------------------------------------------------------------
// Request types and request lengths in bits
// ------------------------------------------------------------------
`define PLRS_RT_IMM   3'h0
`define PLRS_RT_ISO   3'h1
`define PLRS_RT_PRI   3'h2
`define PLRS_RT_FAIR  3'h3
`define PLRS_RT_RD    3'h4
`define PLRS_RT_WR    3'h5
`define PLRS_LEN_BUS  5'h0b
`define PLRS_LEN_RD   5'h09
`define PLRS_LEN_WR   5'h11

// ------------------------------------------------------------------
// Status transfer: last beat index of short and full streams
// ------------------------------------------------------------------
`define PLRS_LAST_SHORT 3'h1
`define PLRS_LAST_FULL  3'h7

// ------------------------------------------------------------------
// APB register map and reset values
// ------------------------------------------------------------------
`define PLRS_OFF_CTRL    8'h00
`define PLRS_OFF_STAT    8'h04
`define PLRS_OFF_PHYREG  8'h40
`define PLRS_CTRL_RESET  2'h1
`define PLRS_CTRL_EN_BIT 0
`define PLRS_CTRL_CANCEL 1

`endif

// ### verilog/plrs_pkg.sv
/*
 * Types shared by the phy-link request and status block.
 * Assumes nothing of its surroundings.
 */
package plrs_pkg;

	// Interface owner and activity, one-hot
	typedef enum logic [6:0] {
		ST_IDLE   = 7'h01,  // Phy drives idle
		ST_RECV   = 7'h02,  // Phy forwards a packet
		ST_STATUS = 7'h04,  // Phy sends status
		ST_GAP    = 7'h08,  // Idle beat after status
		ST_GRANT  = 7'h10,  // Transmit code, one beat
		ST_GIDLE  = 7'h20,  // Idle beat before hand-over
		ST_LINK   = 7'h40   // Link owns the lines
	} plrs_state_t;

endpackage

// ### verilog/plrs_req_if.sv
/*
 * Carrier between the request receiver and the block core.
 * Assumes a single clock shared by both ends.
 */
`timescale 1ns/100ps

interface plrs_req_if;
	logic       busy;   // A request transfer is under way
	logic       done;   // One-cycle pulse: request framed correctly
	logic [2:0] rtype;  // Request type
	logic [3:0] addr;   // Register address
	logic [7:0] wdata;  // Register write data
	logic [3:0] prio;   // Request priority

	modport rx   (output busy, done, rtype, addr, wdata, prio);
	modport core (input  busy, done, rtype, addr, wdata, prio);
endinterface

// ### verilog/plrs_req_rx.sv
/*
 * Serial request receiver: collects the bits on the link request line,
 * sizes the transfer from its type and checks the stop bit.
 * Assumes the line is sampled on pclk and idles low.
 */
`timescale 1ns/100ps
`include "plrs_consts.svh"

module plrs_req_rx (
	input  wire logic   pclk,
	input  wire logic   presetn,
	input  wire logic   link_request_line,
	plrs_req_if.rx      req
);

	logic [16:0] bits_q;  // Collected bits, index is bit number
	logic [4:0]  idx_q;   // Index of the next bit
	logic        act_q;   // Transfer under way
	logic        done_q;  // Completion pulse
	logic [2:0]  typ;     // Type from collected bits

	// ------------------------------------------------------------------
	// Length of a transfer from its type
	// ------------------------------------------------------------------
	function automatic logic [4:0] req_len(input logic [2:0] t);
		case (t)
			`PLRS_RT_RD: req_len = `PLRS_LEN_RD;
			`PLRS_RT_WR: req_len = `PLRS_LEN_WR;
			default:     req_len = `PLRS_LEN_BUS;
		endcase
	endfunction

	assign typ = {bits_q[1], bits_q[2], bits_q[3]};

	// Shift in bits; a start bit of one opens a transfer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			bits_q <= 17'h00000;
			idx_q  <= 5'h00;
			act_q  <= 1'b0;
			done_q <= 1'b0;
		end
		else
		begin
			done_q <= 1'b0;
			if (!act_q)
			begin
				if (link_request_line)
				begin
					act_q     <= 1'b1;
					idx_q     <= 5'h01;
					bits_q    <= 17'h00001;
				end
			end
			else
			begin
				bits_q[idx_q] <= link_request_line;
				idx_q         <= idx_q + 5'h01;
				// Last bit: stop bit must be zero, else drop
				if (idx_q > 5'h03 && idx_q == req_len(typ) - 5'h01)
				begin
					act_q  <= 1'b0;
					done_q <= !link_request_line;
				end
			end
		end
	end

	// Fields are read from the collected bits, most significant first
	assign req.busy  = act_q;
	assign req.done  = done_q;
	assign req.rtype = typ;
	assign req.addr  = {bits_q[4], bits_q[5], bits_q[6], bits_q[7]};
	assign req.prio  = {bits_q[6], bits_q[7], bits_q[8], bits_q[9]};
	assign req.wdata = {bits_q[8], bits_q[9], bits_q[10], bits_q[11],
		bits_q[12], bits_q[13], bits_q[14], bits_q[15]};

endmodule

// ### test/plrs_link_model.sv
/*
 * Link-side model: shifts requests out on the request line and sends
 * idle on the control lines whenever it owns them.
 * Assumes it shares pclk with the phy.
 */
`timescale 1ns/100ps

module plrs_link_model (
	input  wire logic  pclk,
	output logic       link_request_line,
	output logic [1:0] ctl_drive
);
	// Owned lines are handed straight back with two idle beats
	assign ctl_drive = 2'h0;
	// Request line idles low
	initial link_request_line = 1'b0;
	// One bit per rising edge, start bit first, line low afterwards
	task automatic send(input logic [16:0] bits, input int len);
		for (int i = 0; i < len; i++)
		begin
			@(posedge pclk);
			link_request_line <= bits[i];
		end
		@(posedge pclk);
		link_request_line <= 1'b0;
	endtask
endmodule

// ### test/tb.sv
/*
 * Testbench of the phy-link request and status block: APB master,
 * link model and one task per scenario.
 * Assumes the design files and the link model are compiled first.
 */
`timescale 1ns/100ps

module tb;
	// ------------------------------------------------------------
	// Signals, design and link model
	// ------------------------------------------------------------
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        rx_active = 1'b0;
	logic [1:0]  rx_data = 2'h0;
	logic        arb_won = 1'b0;
	logic        evt_arb_reset_gap = 1'b0;
	logic        evt_subaction_gap = 1'b0;
	logic        evt_bus_reset = 1'b0;
	logic [31:0] prdata;
	logic        pready, pslverr, bus_take, arb_request, data_lanes_oe;
	logic        data_lane_zero_o, data_lane_one_o, link_request_line;
	logic [1:0]  interface_control_lines_o, link_ctl;
	logic        interface_control_lines_oe;
	logic [2:0]  arb_type;
	logic [3:0]  arb_prio;
	wire  [1:0]  interface_control_lines_i, ctl;
	int          errors = 0;
	int          checks_done = 0;
	int          cyc = 0;
	int          nb;
	logic [31:0] rd;
	logic        er;
	logic [15:0] w;

	plrs_top i_plrs_top (
		.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr),
		.link_request_line(link_request_line),
		.interface_control_lines_i(interface_control_lines_i),
		.interface_control_lines_o(interface_control_lines_o),
		.interface_control_lines_oe(interface_control_lines_oe),
		.data_lane_zero_o(data_lane_zero_o),
		.data_lane_one_o(data_lane_one_o),
		.data_lanes_oe(data_lanes_oe),
		.rx_active(rx_active), .rx_data(rx_data),
		.arb_won(arb_won),
		.evt_arb_reset_gap(evt_arb_reset_gap),
		.evt_subaction_gap(evt_subaction_gap),
		.evt_bus_reset(evt_bus_reset),
		.arb_request(arb_request), .arb_type(arb_type),
		.arb_prio(arb_prio), .bus_take(bus_take)
	);
	plrs_link_model i_plrs_link_model (
		.pclk              (pclk),
		.link_request_line (link_request_line),
		.ctl_drive         (link_ctl)
	);
	// Wire level: whoever has the enable drives the control lines
	assign interface_control_lines_i = interface_control_lines_oe ?
		interface_control_lines_o : link_ctl;
	assign ctl = interface_control_lines_o;

	always #12.5 pclk = ~pclk;

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e)
		begin
			errors++;
			$display("MISMATCH %0t got %h expected %h", $time, g, e);
		end
	endtask

	// APB transfer: setup, then access held until pready
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// The wait ends once pready is seen high; the hang guard catches a stuck slave
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Start bit, fields msb first, stop bit left at 0
	function automatic logic [16:0] req(input logic [15:0] v, input int n);
		req = 17'h1;
		for (int i = 0; i < n; i++)
			req[1 + i] = v[n - 1 - i];
	endfunction

	task automatic until_ctl(input logic [1:0] c);
		int n;
		n = 0;
		while (ctl !== c && n < 100)
		begin
			@(negedge pclk);
			n++;
		end
		chk(ctl, c);
	endtask

	// Collect one status transfer, two bits per beat
	task automatic grab();
		w = 16'h0;
		nb = 0;
		until_ctl(2'h1);
		while (ctl === 2'h1 && nb < 8)
		begin
			w[2 * nb] = data_lane_zero_o;
			w[2 * nb + 1] = data_lane_one_o;
			nb++;
			@(negedge pclk);
		end
	endtask

	task automatic rx_pulse();
		@(posedge pclk);
		rx_active <= 1'b1;
		@(posedge pclk);
		rx_active <= 1'b0;
		repeat (2) @(negedge pclk);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_regs();
		chk({interface_control_lines_oe, ctl}, 3'h4);
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h1);
		apb(1'b0, 8'h3c, 32'h0);
		chk(er, 1'b1);
		apb(1'b1, 8'h44, 32'h5a);
		apb(1'b0, 8'h44, 32'h0);
		chk(rd, 32'h5a);
		chk(pready, 1'b1);
		i_plrs_link_model.send(req({3'h5, 4'h3, 8'hc5}, 15), 17);
		apb(1'b0, 8'h4c, 32'h0);
		chk(rd, 32'hc5);
		i_plrs_link_model.send(req({3'h4, 4'h3}, 7), 9);
		grab();
		// Address and data reversed, as they leave msb first
		chk(w, 16'ha3c0);
		chk(nb, 8);
		chk(ctl, 2'h0);
		$display("test registers done");
	endtask

	task automatic t_flags();
		@(posedge pclk);
		{evt_bus_reset, evt_subaction_gap, evt_arb_reset_gap} <= 3'h6;
		@(posedge pclk);
		{evt_bus_reset, evt_subaction_gap, evt_arb_reset_gap} <= 3'h0;
		grab();
		chk(w, 16'h0006);
		chk(nb, 2);
		i_plrs_link_model.send(req({3'h4, 4'h3}, 7), 9);
		until_ctl(2'h1);
		@(posedge pclk);
		rx_active <= 1'b1;
		rx_data <= 2'h2;
		repeat (2) @(negedge pclk);
		chk({ctl, data_lane_one_o, data_lane_zero_o}, 4'ha);
		@(posedge pclk);
		rx_active <= 1'b0;
		rx_data <= 2'h0;
		grab();
		chk(w, 16'ha3c0);
		$display("test status done");
	endtask

	// Grant: transmit one beat, idle one beat, then link owns
	task automatic granted();
		until_ctl(2'h3);
		@(negedge pclk);
		chk(ctl, 2'h0);
		@(negedge pclk);
		chk({interface_control_lines_oe, data_lanes_oe}, 2'h0);
		repeat (4) @(negedge pclk);
		chk({interface_control_lines_oe, data_lanes_oe}, 2'h3);
	endtask

	task automatic t_bus();
		// Receive shown while the fair request is still shifting in
		fork
			i_plrs_link_model.send(req({3'h3, 2'h0, 4'h5}, 9), 11);
			rx_pulse();
		join
		repeat (3) @(negedge pclk);
		chk(arb_request, 1'b0);
		i_plrs_link_model.send(req({3'h3, 2'h0, 4'h5}, 9), 11);
		repeat (3) @(negedge pclk);
		chk({arb_request, arb_type, arb_prio}, 8'hb5);
		i_plrs_link_model.send(req({3'h2, 2'h0, 4'h9}, 9), 11);
		repeat (3) @(negedge pclk);
		chk({arb_type, arb_prio}, 7'h35);
		rx_pulse();
		chk(arb_request, 1'b0);
		// Software cancel of a pending request
		i_plrs_link_model.send(req({3'h3, 2'h0, 4'h0}, 9), 11);
		apb(1'b1, 8'h00, 32'h3);
		@(negedge pclk);
		chk(arb_request, 1'b0);
		i_plrs_link_model.send(req({3'h1, 2'h0, 4'h0}, 9), 11);
		repeat (3) @(negedge pclk);
		rx_pulse();
		chk({arb_request, arb_type}, 4'h9);
		@(posedge pclk);
		arb_won <= 1'b1;
		@(posedge pclk);
		arb_won <= 1'b0;
		granted();
		chk(arb_request, 1'b0);
		@(posedge pclk);
		rx_active <= 1'b1;
		i_plrs_link_model.send(req({3'h0, 2'h0, 4'h0}, 9), 11);
		@(posedge pclk);
		rx_active <= 1'b0;
		repeat (2) @(negedge pclk);
		chk({ctl, bus_take}, 3'h7);
		granted();
		$display("test bus requests done");
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Hang guard
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			errors++;
			summarize();
		end
	end

	initial
	begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_flags();
		t_bus();
		summarize();
	end
endmodule
